//--- verilog/emb_bus.sv
// external memory and io bus interface: one strobed cycle per external request
// How it works
// - 16-bit two-way data bus to program, data or io space.
// - data bus released unless driving write data, and during reset.
// - output float puts data, address and all controls in high impedance.
// - 16-bit address bus drives the external address.
// - program select low only during an external program access.
// - data select low only during an external data access.
// - io select low during any io-space access, external or internal io register.
// - ready low stretches the cycle; ready is sampled again next cycle.
// - direction line high for read, low only during a write.
// - bus cycle strobe low marks each external bus cycle.
// - read strobe low during every external read.
// - internal io register accesses still show io select, direction, data.
// - write strobe low on external writes; data valid at its rising edge.
`timescale 1ns/1ps
`default_nettype none
module emb_bus (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire emb_pkg::emb_req_s          req,
  output emb_pkg::emb_rsp_s               rsp,
  input  wire logic [emb_pkg::DATA_W-1:0] data_in,
  input  wire logic                       ready,
  input  wire logic                       test_reset,
  input  wire logic                       emulator_pin0,
  input  wire logic                       emulator_float_pin,
  output emb_pkg::emb_pins_s              pins
);
  typedef struct packed {
    emb_pkg::emb_state_e               state;
    emb_pkg::emb_req_s                 cur;
    emb_pkg::emb_rsp_s                 rsp;
    emb_pkg::emb_pins_s                pins;
  } emb_state_s;

  emb_state_s st_reg;
  emb_state_s st_next;
  logic       ready_sync;
  logic       float_all;
  logic [emb_pkg::DATA_W-1:0] data_sync;

  emb_sync #(.WIDTH(1)) u_ready_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (ready),
    .q     (ready_sync)
  );

  // read data is stable while the strobe is low, so a plain two-flop path is enough
  emb_sync #(.WIDTH(emb_pkg::DATA_W)) u_data_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (data_in),
    .q     (data_sync)
  );

  emb_float_ctl u_float (
    .clk                (clk),
    .rst_n              (rst_n),
    .test_reset         (test_reset),
    .emulator_pin0      (emulator_pin0),
    .emulator_float_pin (emulator_float_pin),
    .float_all          (float_all)
  );

  // one-hot select decode, used only for the select pins
  function automatic logic [2:0] space_sel_n(input emb_pkg::emb_space_e sp,
                                             input logic on, input logic intio);
    logic [2:0] s;
    s = 3'h7;
    if (on) begin
      case (sp)
        emb_pkg::EMB_SPACE_PROG: s = intio ? 3'h7 : 3'h6;
        emb_pkg::EMB_SPACE_DATA: s = intio ? 3'h7 : 3'h5;
        emb_pkg::EMB_SPACE_IO:   s = 3'h3;
        default:                 s = 3'h7;
      endcase
    end
    return s;
  endfunction : space_sel_n

  logic [2:0] sel_n;

  always_comb begin
    st_next          = st_reg;
    st_next.rsp.done = 1'b0;
    sel_n            = 3'h7;
    case (st_reg.state)
      emb_pkg::EMB_ST_IDLE: begin
        if (req.valid) begin
          st_next.cur      = req;
          st_next.state    = emb_pkg::EMB_ST_STROBE;
          st_next.rsp.busy = 1'b1;
          sel_n = space_sel_n(req.space, 1'b1, req.internal_io);
          st_next.pins.addr                   = req.addr;
          st_next.pins.program_space_select_n = sel_n[0];
          st_next.pins.data_space_select_n    = sel_n[1];
          st_next.pins.io_space_select_n      = sel_n[2];
          st_next.pins.read_write_dir         = !req.write;
          // internal io register accesses show only select, address, direction and data
          st_next.pins.bus_cycle_strobe_n     = req.internal_io;
          st_next.pins.read_strobe_n          = req.write || req.internal_io;
          st_next.pins.write_strobe_n         = !req.write || req.internal_io;
          st_next.pins.data_out               = req.wdata;
          st_next.pins.data_oe_n              = !req.write;
        end
      end
      emb_pkg::EMB_ST_STROBE: begin
        // ready low holds every pin except ctrl_oe_n as is for one more cycle
        if (ready_sync || st_reg.cur.internal_io) begin
          st_next.state                   = emb_pkg::EMB_ST_DONE;
          st_next.rsp.rdata               = data_sync;
          st_next.pins.bus_cycle_strobe_n = 1'b1;
          st_next.pins.read_strobe_n      = 1'b1;
          st_next.pins.write_strobe_n     = 1'b1;
        end
      end
      emb_pkg::EMB_ST_DONE: begin
        // data held one cycle past write strobe rise so it is valid at the edge
        st_next.state                       = emb_pkg::EMB_ST_IDLE;
        st_next.rsp.busy                    = 1'b0;
        st_next.rsp.done                    = 1'b1;
        st_next.pins.program_space_select_n = 1'b1;
        st_next.pins.data_space_select_n    = 1'b1;
        st_next.pins.io_space_select_n      = 1'b1;
        st_next.pins.read_write_dir         = 1'b1;
        st_next.pins.data_oe_n              = 1'b1;
      end
      default: begin
        st_next.state = emb_pkg::EMB_ST_IDLE;
      end
    endcase
    st_next.pins.ctrl_oe_n = float_all;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg                             <= '0;
      st_reg.state                       <= emb_pkg::EMB_ST_IDLE;
      st_reg.pins.addr                   <= emb_pkg::RESET_ADDR;
      st_reg.pins.data_out               <= emb_pkg::RESET_DATA;
      st_reg.pins.data_oe_n              <= 1'b1;
      st_reg.pins.ctrl_oe_n              <= 1'b0;
      st_reg.pins.program_space_select_n <= 1'b1;
      st_reg.pins.data_space_select_n    <= 1'b1;
      st_reg.pins.io_space_select_n      <= 1'b1;
      st_reg.pins.read_write_dir         <= 1'b1;
      st_reg.pins.bus_cycle_strobe_n     <= 1'b1;
      st_reg.pins.read_strobe_n          <= 1'b1;
      st_reg.pins.write_strobe_n         <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // data oe is not forced off while floating; pins come straight from the flops
  always_comb begin
    pins = st_reg.pins;
  end
  assign rsp = st_reg.rsp;

  // float: data driver gated by ctrl_oe_n at the pad; external pad uses
  // data_oe_n | ctrl_oe_n, so both stay flop outputs

  AST_ONE_SELECT: assert property (@(posedge clk) disable iff (!rst_n)
    $countones({pins.program_space_select_n, pins.data_space_select_n,
                pins.io_space_select_n}) >= 2) else $error("two space selects low");

  AST_WRITE_DIR: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.write_strobe_n |-> !pins.read_write_dir && !pins.data_oe_n)
    else $error("write strobe without write direction or data");

  AST_READ_NO_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.read_strobe_n |-> pins.data_oe_n && pins.read_write_dir)
    else $error("data driven during read");

  AST_STROBE_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.bus_cycle_strobe_n && $past(!pins.bus_cycle_strobe_n) |->
      $stable(pins.addr) && $stable(pins.read_write_dir) &&
      $stable({pins.program_space_select_n, pins.data_space_select_n,
               pins.io_space_select_n}))
    else $error("address or select moved in strobe");

  AST_WAIT_READY: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.state == emb_pkg::EMB_ST_STROBE && !ready_sync && !st_reg.cur.internal_io
      |=> st_reg.state == emb_pkg::EMB_ST_STROBE)
    else $error("cycle ended with ready low");

  AST_READY_END: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.state == emb_pkg::EMB_ST_STROBE && ready_sync |=> pins.bus_cycle_strobe_n
      ##1 rsp.done)
    else $error("ready high did not end the cycle");

  AST_DATA_AFTER_WE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins.write_strobe_n) |-> !pins.data_oe_n && $stable(pins.data_out))
    else $error("write data not valid at write strobe rise");

  AST_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
    float_all |=> pins.ctrl_oe_n)
    else $error("float not applied");

  AST_IO_SELECT: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.io_space_select_n |-> st_reg.cur.space == emb_pkg::EMB_SPACE_IO)
    else $error("io select outside io access");
endmodule : emb_bus
`default_nettype wire

//--- verilog/emb_pkg.sv
// package: constants, types and carriers for the external memory/io bus
package emb_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 16;

  typedef enum logic [1:0] {
    EMB_SPACE_PROG = 2'h0,
    EMB_SPACE_DATA = 2'h1,
    EMB_SPACE_IO   = 2'h2
  } emb_space_e;

  typedef enum logic [1:0] {
    EMB_ST_IDLE   = 2'h0,
    EMB_ST_STROBE = 2'h1,
    EMB_ST_DONE   = 2'h3
  } emb_state_e;

  // core-side request
  typedef struct packed {
    logic              valid;
    logic              write;
    logic              internal_io;
    emb_space_e        space;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } emb_req_s;

  // core-side answer
  typedef struct packed {
    logic              busy;
    logic              done;
    logic [DATA_W-1:0] rdata;
  } emb_rsp_s;

  // pin-side outputs; *_oe_n low means the pin is driven
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out;
    logic              data_oe_n;
    logic              ctrl_oe_n;
    logic              program_space_select_n;
    logic              data_space_select_n;
    logic              io_space_select_n;
    logic              read_write_dir;
    logic              bus_cycle_strobe_n;
    logic              read_strobe_n;
    logic              write_strobe_n;
  } emb_pins_s;

  localparam logic [DATA_W-1:0] RESET_DATA = 16'h0000;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 16'h0000;
  localparam int unsigned SYNC_STAGES = 2;
endpackage : emb_pkg

//--- verilog/emb_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module emb_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } emb_sync_s;

  emb_sync_s st_reg;
  emb_sync_s st_next;

  // first stage feeds only the second
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule : emb_sync
`default_nettype wire

//--- verilog/emb_float_ctl.sv
// decodes the output-float condition from the test pins
`timescale 1ns/1ps
`default_nettype none
module emb_float_ctl (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic test_reset,
  input  wire logic emulator_pin0,
  input  wire logic emulator_float_pin,
  output logic      float_all
);
  logic [2:0] pins_sync;
  logic       float_reg;
  logic       float_next;

  emb_sync #(.WIDTH(3)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({test_reset, emulator_pin0, emulator_float_pin}),
    .q     (pins_sync)
  );

  // float only for test reset low, pin0 high, float pin low
  always_comb begin
    float_next = !pins_sync[2] && pins_sync[1] && !pins_sync[0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      float_reg <= 1'b0;
    end else begin
      float_reg <= float_next;
    end
  end

  assign float_all = float_reg;
endmodule : emb_float_ctl
`default_nettype wire

//--- tb/emb_mem_model.sv
// external memory and io device model on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
  input  wire logic               clk,
  input  wire emb_pkg::emb_pins_s pins,
  input  wire logic [1:0]         lat,
  output logic [15:0]             data_in,
  output logic                    ready
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] last;
  logic [1:0]  sp;
  int          cnt;
  assign sp = !pins.program_space_select_n ? 2'h0 : !pins.data_space_select_n ? 2'h1 : 2'h2;
  always @(posedge clk) cnt <= pins.bus_cycle_strobe_n ? 0 : cnt + 1;
  // slow device: ready only after lat cycles of strobe low
  assign ready = !pins.bus_cycle_strobe_n && cnt >= lat;
  // latch write data on the rising write strobe
  always @(posedge pins.write_strobe_n) if (!pins.ctrl_oe_n) mem[{sp, pins.addr}] = pins.data_out;
  always @(posedge clk) last <= data_in;
  // read strobe is the output enable; released pad toggles
  always @* begin
    if (!pins.ctrl_oe_n && !pins.data_oe_n) data_in = pins.data_out;
    else if (!pins.ctrl_oe_n && !pins.read_strobe_n) data_in = mem[{sp, pins.addr}];
    else data_in = ~last;
  end
endmodule : emb_mem_model
`default_nettype wire

//--- tb/external_memory_io_bus_bench.sv
// self-checking bench for the external memory and io bus
`timescale 1ns/1ps
`default_nettype none
module external_memory_io_bus_bench;
  logic clk, rst_n, ready, tr, e0, ef;
  logic [15:0] data_in;
  logic [1:0] lat;
  emb_pkg::emb_req_s req;
  emb_pkg::emb_rsp_s rsp;
  emb_pkg::emb_pins_s pins;
  logic [15:0] ref_mem [int];
  logic [31:0] seed;
  int n_errors, samples_checked;
  emb_bus uut (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp), .data_in(data_in),
    .ready(ready), .test_reset(tr), .emulator_pin0(e0), .emulator_float_pin(ef), .pins(pins));
  emb_mem_model mdl (.clk(clk), .pins(pins), .lat(lat), .data_in(data_in), .ready(ready));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic xfer(input bit wr, input bit iio, input logic [1:0] sp, input logic [15:0] a,
                      input logic [15:0] wd, input logic [1:0] l);
    int k, ns;
    bit saw;
    logic [2:0] se, s;
    lat = l;
    se = (iio && sp != 2'h2) ? 3'b111 : ~(3'b100 >> sp);
    req = {1'b1, wr, iio, sp, a, wd};
    @(posedge clk);
    #1 req.valid = 1'b0;
    ns = 0;
    saw = 0;
    for (k = 0; k < 40 && rsp.done !== 1'b1; k++) begin
      s = {pins.program_space_select_n, pins.data_space_select_n, pins.io_space_select_n};
      if (pins.bus_cycle_strobe_n === 1'b0) ns++;
      if (s !== 3'b111) begin
        saw = 1;
        chk(s, se);
        chk(pins.addr, a);
        chk(pins.read_write_dir, !wr);
      end
      if (pins.read_strobe_n === 1'b0) chk(wr, 0);
      if (pins.write_strobe_n === 1'b0) chk({pins.data_oe_n, pins.data_out}, {1'b0, wd});
      if (!wr && !iio) chk(pins.data_oe_n, 1);
      if (wr && s !== 3'b111) chk({pins.data_oe_n, pins.data_out}, {1'b0, wd});
      @(posedge clk);
      #1;
    end
    if (k == 40) begin
      n_errors++;
      print_verdict();
    end
    chk(saw, se != 3'b111);
    if (iio) chk(ns, 0);
    else chk(ns > l, 1);
    if (!wr && !iio) chk(rsp.rdata, ref_mem[{sp, a}]);
    if (wr && !iio) ref_mem[{sp, a}] = wd;
  endtask : xfer
  initial begin
    logic [15:0] a, d;
    logic [1:0] sp;
    seed = 32'h6ea9_f919;
    rst_n = 0;
    {tr, e0, ef} = 3'b011;
    lat = 0;
    req = '0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    repeat (5) @(posedge clk);
    #1;
    for (int i = 0; i < 16; i++) begin
      sp = 2'(rnd() % 3);
      a = 16'(rnd());
      d = 16'(rnd());
      xfer(1, 0, sp, a, d, 2'(rnd()));
      xfer(0, 0, sp, a, d, 2'(rnd()));
    end
    for (int i = 0; i < 3; i++) begin
      xfer(1, 1, 2'(i), 16'h0010, 16'h5a5a, 0);
      xfer(0, 1, 2'(i), 16'h0010, 16'h0000, 0);
    end
    // every test-pin combination; only one of them floats the bus
    for (int c = 0; c < 8; c++) begin
      {tr, e0, ef} = 3'(c);
      repeat (5) @(posedge clk);
      #1 chk(pins.ctrl_oe_n, c == 2);
    end
    {tr, e0, ef} = 3'b011;
    repeat (5) @(posedge clk);
    // reset in mid-write must release the data driver and raise write strobe, cycle strobe and direction
    #1 req = {1'b1, 1'b1, 1'b0, 2'h1, 16'h1234, 16'hbeef};
    lat = 3;
    repeat (2) @(posedge clk);
    #1 rst_n = 0;
    #1 chk({pins.data_oe_n, pins.write_strobe_n, pins.bus_cycle_strobe_n}, 3'b111);
    chk(pins.read_write_dir, 1);
    // the bus must work again after a mid-run reset
    req = '0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    #1;
    xfer(1, 0, 2'h1, 16'h00a5, 16'h3c3c, 2'h1);
    xfer(0, 0, 2'h1, 16'h00a5, 16'h0000, 2'h2);
    print_verdict();
  end
endmodule : external_memory_io_bus_bench
`default_nettype wire
